//--- hdl/lpac_top.sv
/*
 * Low-power activity supervisor: APB registers, inactivity timers,
 * ignition monitor, alert requests, sleep output and LED flasher.
 * Assumes inputs synchronous to sys_clk; activity pulses mark chars.
 */
// The APB slave port is this design's own decision.
// Summary of operation
// - no low-power function unless power master set
// - full-power pin inverted while asleep
// - serial auto-sleep after serial inactivity timeout
// - serial timeout 5 or 20 minutes
// - serial warning alert one minute before
// - ignition low enters sleep when enabled
// - ignition high waits 1 or 5 s
// - monitor master gates bits 3 to 6
// - wake on bus idle-to-active transition
// - bus auto-sleep after bus inactivity timeout
// - bus timeout 30 or 150 seconds
// - bus warning alert at bus timeout
// - exclamation before both alert messages
// - LED 16 ms flash every 4 s asleep
// - power options apply after next reset
// - monitor options apply after defaults or reset
`timescale 1ns/1ps
module lpac_top (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // device-side events
    input  wire logic               soft_reset,
    input  wire logic               restore_defaults,
    input  wire logic               serial_activity,
    input  wire logic               bus_activity,
    input  wire logic               ignition_monitor_input,
    // alert request to the serial transmitter
    output lpac_pkg::lpac_alert_t   alert,
    input  wire logic               alert_ack,
    // pins
    output logic                    full_power_out,
    output logic                    legacy_mode,
    output logic                    tx_led,
    output logic                    sleeping,
    output logic                    irq
);
    logic [7:0]  pwr_stored;
    logic [7:0]  act_stored;
    logic [7:0]  pwr;
    logic [7:0]  act;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [3:0]  ev;
    logic        wr;
    logic        rd;
    logic        lp_en;
    logic        am_en;
    logic        tick;
    logic [15:0] tick_cnt;
    logic [20:0] ser_ms;
    logic [20:0] bus_ms;
    logic [20:0] ign_ms;
    logic [20:0] led_ms;
    logic [20:0] ser_lim;
    logic [20:0] bus_lim;
    logic [20:0] ign_lim;
    logic        ser_warned;
    logic        bus_idle;
    logic        bus_fired;
    logic        ign_low_seen;
    logic        go_sleep;
    logic        go_wake;
    logic        ser_warn_now;
    logic        bus_alert_now;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // stored option values, written by software
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pwr_stored <= lpac_pkg::PWR_RESET;
            act_stored <= lpac_pkg::ACT_RESET;
            mask       <= lpac_pkg::MASK_RESET;
        end else if (wr) begin
            case (paddr)
                lpac_pkg::PWR_ADDR:  pwr_stored <= pwdata[7:0];
                lpac_pkg::ACT_ADDR:  act_stored <= pwdata[7:0];
                lpac_pkg::MASK_ADDR: mask <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // effective options: power loaded on reset, monitor on reset or default restore
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pwr <= lpac_pkg::PWR_RESET;
            act <= lpac_pkg::ACT_RESET;
        end else begin
            if (soft_reset) begin
                pwr <= pwr_stored;
            end
            if (soft_reset || restore_defaults) begin
                act <= act_stored;
            end
        end
    end

    assign lp_en = pwr[lpac_pkg::PW_MASTER];
    assign am_en = lp_en && act[lpac_pkg::AM_MASTER];
    assign legacy_mode = !lp_en;

    // read data registered in the setup phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            case (paddr)
                lpac_pkg::PWR_ADDR:  prdata <= {24'h0, pwr_stored};
                lpac_pkg::ACT_ADDR:  prdata <= {24'h0, act_stored};
                lpac_pkg::STAT_ADDR: prdata <= {28'h0, status};
                lpac_pkg::IRQ_ADDR:  prdata <= {28'h0, status & mask};
                lpac_pkg::MASK_ADDR: prdata <= {28'h0, mask};
                lpac_pkg::CTL_ADDR:
                    prdata <= {29'h0, ign_low_seen, bus_idle, sleeping};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

    // 1 ms tick divider
    always_ff @(posedge sys_clk) begin
        if (rst || tick_cnt == 16'(lpac_pkg::TICK_CYC - 1)) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end
    assign tick = (tick_cnt == 16'(lpac_pkg::TICK_CYC - 1));

    assign ser_lim = pwr[lpac_pkg::PW_TSEL] ? lpac_pkg::SER_LONG_MS
                                            : lpac_pkg::SER_SHORT_MS;
    assign bus_lim = act[lpac_pkg::AM_TSEL] ? lpac_pkg::BUS_LONG_MS
                                            : lpac_pkg::BUS_SHORT_MS;
    assign ign_lim = pwr[lpac_pkg::PW_IGNDLY] ? lpac_pkg::IGN_LONG_MS
                                              : lpac_pkg::IGN_SHORT_MS;

    // serial inactivity timer
    always_ff @(posedge sys_clk) begin
        if (rst || serial_activity || sleeping) begin
            ser_ms <= 21'h0;
        end else if (tick && ser_ms != ser_lim) begin
            ser_ms <= ser_ms + 21'h1;
        end
    end
    assign ser_warn_now = lp_en && pwr[lpac_pkg::PW_AUTO]
        && pwr[lpac_pkg::PW_WARN] && !ser_warned
        && ser_ms == ser_lim - lpac_pkg::SER_WARN_MS;
    always_ff @(posedge sys_clk) begin
        if (rst || serial_activity || sleeping) begin
            ser_warned <= 1'b0;
        end else if (ser_warn_now) begin
            ser_warned <= 1'b1;
        end
    end

    // bus inactivity timer and idle tracking
    always_ff @(posedge sys_clk) begin
        if (rst || bus_activity) begin
            bus_ms <= 21'h0;
        end else if (tick && bus_ms != bus_lim) begin
            bus_ms <= bus_ms + 21'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || bus_activity) begin
            bus_idle <= 1'b0;
        end else if (bus_ms == bus_lim) begin
            bus_idle <= 1'b1;
        end
    end
    assign bus_alert_now = am_en && act[lpac_pkg::AM_WARN] && !bus_fired
        && !sleeping && bus_ms == bus_lim;
    always_ff @(posedge sys_clk) begin
        if (rst || bus_activity) begin
            bus_fired <= 1'b0;
        end else if (bus_ms == bus_lim && !sleeping) begin
            bus_fired <= 1'b1;
        end
    end

    // ignition release delay
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ign_low_seen <= 1'b0;
            ign_ms       <= 21'h0;
        end else if (!ignition_monitor_input) begin
            ign_low_seen <= lp_en && pwr[lpac_pkg::PW_IGN];
            ign_ms       <= 21'h0;
        end else if (ign_low_seen && tick) begin
            if (ign_ms + 21'h1 >= ign_lim) begin
                ign_low_seen <= 1'b0;
            end else begin
                ign_ms <= ign_ms + 21'h1;
            end
        end
    end

    assign go_sleep = !sleeping && lp_en && (
        (pwr[lpac_pkg::PW_AUTO] && ser_ms == ser_lim)
        || (am_en && act[lpac_pkg::AM_AUTO] && bus_ms == bus_lim
            && !bus_fired)
        || (pwr[lpac_pkg::PW_IGN] && !ignition_monitor_input));
    // ignition still low with ignition control set keeps the device asleep unless the power master is cleared
    assign go_wake = sleeping && (!lp_en || (!ign_low_seen
        && !(pwr[lpac_pkg::PW_IGN] && !ignition_monitor_input) && (
        serial_activity
        || (am_en && act[lpac_pkg::AM_WAKE] && bus_idle
            && bus_activity))));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sleeping <= 1'b0;
        end else if (go_sleep) begin
            sleeping <= 1'b1;
        end else if (go_wake) begin
            sleeping <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            full_power_out <= lpac_pkg::PWR_RESET[lpac_pkg::PW_LEVEL];
        end else begin
            full_power_out <= pwr[lpac_pkg::PW_LEVEL]
                              ^ (sleeping && lp_en);
        end
    end

    // alert request held until acknowledged
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alert <= '{valid: 1'b0, excl: 1'b0, kind: lpac_pkg::MSG_NONE};
        end else if (go_sleep) begin
            alert.valid <= 1'b1;
            alert.excl  <= act[lpac_pkg::AM_EXCL];
            alert.kind  <= lpac_pkg::MSG_SLEEP;
        end else if (ser_warn_now || bus_alert_now) begin
            alert.valid <= 1'b1;
            alert.excl  <= act[lpac_pkg::AM_EXCL];
            alert.kind  <= lpac_pkg::MSG_ACT;
        end else if (alert_ack) begin
            alert.valid <= 1'b0;
        end
    end

    // led flasher
    always_ff @(posedge sys_clk) begin
        if (rst || !sleeping) begin
            led_ms <= 21'h0;
        end else if (tick) begin
            led_ms <= (led_ms == lpac_pkg::LED_PER_CNT - 21'h1)
                      ? 21'h0 : led_ms + 21'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_led <= 1'b0;
        end else begin
            tx_led <= sleeping && lp_en
                && act[lpac_pkg::AM_LED]
                && led_ms < lpac_pkg::LED_ON_CNT;
        end
    end

    // sticky events, set wins over write-one clear
    assign ev[lpac_pkg::EV_SLEEP] = go_sleep;
    assign ev[lpac_pkg::EV_WAKE]  = go_wake;
    assign ev[lpac_pkg::EV_ACT]   = ser_warn_now || bus_alert_now;
    assign ev[lpac_pkg::EV_LPA]   = go_sleep;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status <= 4'h0;
        end else if (wr && paddr == lpac_pkg::STAT_ADDR) begin
            status <= (status & ~pwdata[3:0]) | ev;
        end else begin
            status <= status | ev;
        end
    end
    assign irq = |(status & mask);

    property p_sleep_pin;
        @(posedge sys_clk) disable iff (rst)
        (sleeping && lp_en) |=>
            full_power_out == !$past(pwr[lpac_pkg::PW_LEVEL]);
    endproperty
    a_sleep_pin: assert property (p_sleep_pin)
        else $error("full power pin not inverted in sleep");

    property p_no_lp_when_off;
        @(posedge sys_clk) disable iff (rst)
        (!lp_en && !sleeping) |=> !sleeping;
    endproperty
    a_no_lp_when_off: assert property (p_no_lp_when_off)
        else $error("sleep entered with master off");

    property p_ign_sleep;
        @(posedge sys_clk) disable iff (rst)
        (lp_en && pwr[lpac_pkg::PW_IGN] && !ignition_monitor_input)
            |=> sleeping;
    endproperty
    a_ign_sleep: assert property (p_ign_sleep)
        else $error("ignition low did not enter sleep");

    property p_ser_timer_restart;
        @(posedge sys_clk) disable iff (rst)
        serial_activity |=> ser_ms == 21'h0;
    endproperty
    a_ser_timer_restart: assert property (p_ser_timer_restart)
        else $error("serial timer not restarted");

    property p_bus_alert;
        @(posedge sys_clk) disable iff (rst)
        bus_alert_now |=> alert.valid && alert.kind != lpac_pkg::MSG_NONE;
    endproperty
    a_bus_alert: assert property (p_bus_alert)
        else $error("bus timeout alert not raised");

    property p_led_off_awake;
        @(posedge sys_clk) disable iff (rst)
        !sleeping |=> !tx_led;
    endproperty
    a_led_off_awake: assert property (p_led_off_awake)
        else $error("led lit while awake");

    property p_wake_gate;
        @(posedge sys_clk) disable iff (rst)
        (sleeping && !act[lpac_pkg::AM_MASTER] && lp_en && !serial_activity)
            |=> sleeping;
    endproperty
    a_wake_gate: assert property (p_wake_gate)
        else $error("woke with monitor master off");

    property p_cfg_hold;
        @(posedge sys_clk) disable iff (rst)
        (!soft_reset) |=> pwr == $past(pwr);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("power options changed without reset");

    // any alert source raised this cycle
    sequence s_alert_raised;
        go_sleep || ser_warn_now || bus_alert_now;
    endsequence

    property p_excl_flag;
        @(posedge sys_clk) disable iff (rst)
        s_alert_raised |=>
            alert.valid && alert.excl == $past(act[lpac_pkg::AM_EXCL]);
    endproperty
    a_excl_flag: assert property (p_excl_flag)
        else $error("exclamation flag not taken from options");

    property p_led_flash;
        @(posedge sys_clk) disable iff (rst)
        (sleeping && lp_en && act[lpac_pkg::AM_LED]
            && led_ms < lpac_pkg::LED_ON_CNT) |=> tx_led;
    endproperty
    a_led_flash: assert property (p_led_flash)
        else $error("led not lit in sleep flash window");
endmodule

//--- hdl/lpac_pkg.sv
/*
 * Package for the low-power activity supervisor: register map, reset
 * values, option bit positions and timing constants.
 * Assumes a 50 MHz system clock and an APB slave with 32-bit data.
 */
package lpac_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;

    // register byte addresses (index times four)
    localparam logic [7:0] PWR_IDX = 8'h0E;
    localparam logic [7:0] ACT_IDX = 8'h0F;
    localparam logic [11:0] PWR_ADDR = {2'b00, PWR_IDX, 2'b00};
    localparam logic [11:0] ACT_ADDR = {2'b00, ACT_IDX, 2'b00};
    localparam logic [11:0] STAT_ADDR = 12'h080;
    localparam logic [11:0] IRQ_ADDR = 12'h084;
    localparam logic [11:0] MASK_ADDR = 12'h088;
    localparam logic [11:0] CTL_ADDR = 12'h08C;

    localparam logic [7:0] PWR_RESET = 8'h9A;
    localparam logic [7:0] ACT_RESET = 8'hD5;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // power control bit positions
    localparam int PW_MASTER = 7;
    localparam int PW_LEVEL = 6;
    localparam int PW_AUTO = 5;
    localparam int PW_TSEL = 4;
    localparam int PW_WARN = 3;
    localparam int PW_IGN = 2;
    localparam int PW_IGNDLY = 1;
    // activity monitor bit positions
    localparam int AM_MASTER = 7;
    localparam int AM_WAKE = 6;
    localparam int AM_AUTO = 5;
    localparam int AM_TSEL = 4;
    localparam int AM_WARN = 3;
    localparam int AM_EXCL = 1;
    localparam int AM_LED = 0;

    // event bits: 0 sleep entered, 1 woke, 2 activity_alert_message, 3 sleep alert
    localparam int EV_SLEEP = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_ACT = 2;
    localparam int EV_LPA = 3;

    // all timing counted in milliseconds from a 1 ms tick
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned SER_SHORT_MIN = 5;
    localparam int unsigned SER_LONG_MIN = 20;
    localparam int unsigned SER_WARN_MIN = 1;
    localparam int unsigned BUS_SHORT_S = 30;
    localparam int unsigned BUS_LONG_S = 150;
    localparam int unsigned IGN_SHORT_S = 1;
    localparam int unsigned IGN_LONG_S = 5;
    localparam int unsigned LED_ON_MS = 16;
    localparam int unsigned LED_PERIOD_S = 4;
    localparam logic [20:0] SER_SHORT_MS = 21'(SER_SHORT_MIN * 60_000);
    localparam logic [20:0] SER_LONG_MS = 21'(SER_LONG_MIN * 60_000);
    localparam logic [20:0] SER_WARN_MS = 21'(SER_WARN_MIN * 60_000);
    localparam logic [20:0] BUS_SHORT_MS = 21'(BUS_SHORT_S * 1000);
    localparam logic [20:0] BUS_LONG_MS = 21'(BUS_LONG_S * 1000);
    localparam logic [20:0] IGN_SHORT_MS = 21'(IGN_SHORT_S * 1000);
    localparam logic [20:0] IGN_LONG_MS = 21'(IGN_LONG_S * 1000);
    localparam logic [20:0] LED_ON_CNT = 21'(LED_ON_MS);
    localparam logic [20:0] LED_PER_CNT = 21'(LED_PERIOD_S * 1000);

    typedef enum logic [1:0] {MSG_NONE, MSG_ACT, MSG_SLEEP} lpac_msg_t;

    typedef struct packed {
        logic      valid;
        logic      excl;
        lpac_msg_t kind;
    } lpac_alert_t;
endpackage

//--- tb/lpac_host_model.sv
/*
 * Host side of the alert path: acknowledges each alert request after a
 * programmable number of cycles, like a serial transmitter draining it.
 * Assumes alert holds valid until acknowledged, ack is a one-cycle pulse.
 */
`timescale 1ns/1ps
module lpac_host_model #(
    parameter int ACK_DELAY = 3
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // alert handshake
    input  wire lpac_pkg::lpac_alert_t alert,
    output logic                       alert_ack
);
    int cnt;

    // zero delay answers promptly, larger values model a busy link
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt       <= 0;
            alert_ack <= 1'b0;
        end else if (alert_ack) begin
            alert_ack <= 1'b0;
            cnt       <= 0;
        end else if (alert.valid === 1'b1) begin
            if (cnt >= ACK_DELAY) begin
                alert_ack <= 1'b1;
            end else begin
                cnt <= cnt + 1;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule

//--- tb/testbench.sv
/*
 * Self-checking bench for the low-power supervisor: APB register access,
 * option staging, ignition sleep, full-power pin, status and interrupt.
 * Assumes a 50 MHz clock and a 1 ms internal tick of 50000 cycles.
 */
`timescale 1ns/1ps
module testbench;
    logic                  sys_clk;
    logic                  rst;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  soft_reset;
    logic                  restore_defaults;
    logic                  serial_activity;
    logic                  bus_activity;
    logic                  ignition_monitor_input;
    lpac_pkg::lpac_alert_t alert;
    logic                  alert_ack;
    logic                  full_power_out;
    logic                  legacy_mode;
    logic                  tx_led;
    logic                  sleeping;
    logic                  irq;
    logic [31:0]           rd;
    int                    errors;
    int                    n_checks;

    lpac_top u_lpac_top (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .soft_reset(soft_reset),
        .restore_defaults(restore_defaults),
        .serial_activity(serial_activity), .bus_activity(bus_activity),
        .ignition_monitor_input(ignition_monitor_input), .alert(alert),
        .alert_ack(alert_ack), .full_power_out(full_power_out),
        .legacy_mode(legacy_mode), .tx_led(tx_led), .sleeping(sleeping),
        .irq(irq)
    );

    lpac_host_model #(.ACK_DELAY(3)) u_lpac_host_model (
        .sys_clk(sys_clk), .rst(rst), .alert(alert), .alert_ack(alert_ack)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // setup cycle, then access held until pready seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 100) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        apb(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask

    task automatic pulse_soft;
        @(posedge sys_clk);
        soft_reset <= 1'b1;
        @(posedge sys_clk);
        soft_reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // bounded wait on the sleep output
    task automatic wait_sleep(input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge sys_clk);
            if (sleeping === v) break;
        end
        if (i == lim) begin
            errors++;
            end_sim();
        end
    endtask

    initial begin
        errors = 0;
        n_checks = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        soft_reset = 1'b0;
        restore_defaults = 1'b0;
        serial_activity = 1'b0;
        bus_activity = 1'b0;
        ignition_monitor_input = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        // register defaults and access
        rd_chk(lpac_pkg::PWR_ADDR, 32'h0000_009A);
        rd_chk(lpac_pkg::ACT_ADDR, 32'h0000_00D5);
        rd_chk(lpac_pkg::MASK_ADDR, 32'h0000_0000);
        rd_chk(lpac_pkg::STAT_ADDR, 32'h0000_0000);
        wr(12'h100, 32'h0000_00FF);
        rd_chk(12'h100, 32'h0000_0000);
        check({31'h0, pslverr}, 32'h0);
        // monitor option keeps its reserved bit 2 set
        wr(lpac_pkg::ACT_ADDR, 32'h0000_0057);
        rd_chk(lpac_pkg::ACT_ADDR, 32'h0000_0057);
        // ignition control staged but not yet in effect
        ignition_monitor_input <= 1'b0;
        wr(lpac_pkg::PWR_ADDR, 32'h0000_009E);
        rd_chk(lpac_pkg::PWR_ADDR, 32'h0000_009E);
        serial_activity <= 1'b1;
        bus_activity <= 1'b1;
        @(posedge sys_clk);
        serial_activity <= 1'b0;
        bus_activity <= 1'b0;
        repeat (52000) @(posedge sys_clk);
        check({31'h0, sleeping}, 32'h0);
        ignition_monitor_input <= 1'b1;
        pulse_soft();
        check({31'h0, legacy_mode}, 32'h0);
        check({31'h0, full_power_out}, 32'h0);
        // ignition off now enters sleep
        ignition_monitor_input <= 1'b0;
        wait_sleep(1'b1, 60000);
        repeat (2) @(posedge sys_clk);
        check({31'h0, full_power_out}, 32'h1);
        check({28'h0, alert}, 32'h0000_000E);
        check({31'h0, tx_led}, 32'h1);
        rd_chk(lpac_pkg::CTL_ADDR, 32'h0000_0005);
        // sleep event, mask, interrupt, clear
        apb(1'b0, lpac_pkg::STAT_ADDR, 32'h0, rd);
        check(rd, 32'h0000_0009);
        check({31'h0, irq}, 32'h0);
        wr(lpac_pkg::MASK_ADDR, 32'h0000_0001);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        rd_chk(lpac_pkg::IRQ_ADDR, 32'h0000_0001);
        wr(lpac_pkg::STAT_ADDR, 32'h0000_0001);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, lpac_pkg::STAT_ADDR, 32'h0, rd);
        check(rd, 32'h0000_0008);
        // master enable off removes every low-power function
        wr(lpac_pkg::PWR_ADDR, 32'h0000_0004);
        pulse_soft();
        check({31'h0, legacy_mode}, 32'h1);
        wait_sleep(1'b0, 60000);
        repeat (2) @(posedge sys_clk);
        check({31'h0, tx_led}, 32'h0);
        check({31'h0, alert.valid}, 32'h0);
        rd_chk(lpac_pkg::STAT_ADDR, 32'h0000_000A);
        // restoring defaults leaves power options alone
        wr(lpac_pkg::PWR_ADDR, 32'h0000_009A);
        @(posedge sys_clk);
        restore_defaults <= 1'b1;
        @(posedge sys_clk);
        restore_defaults <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check({31'h0, legacy_mode}, 32'h1);
        check({31'h0, sleeping}, 32'h0);
        // a second reset brings back the documented option values
        rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(lpac_pkg::PWR_ADDR, 32'h0000_009A);
        rd_chk(lpac_pkg::ACT_ADDR, 32'h0000_00D5);
        check({31'h0, legacy_mode}, 32'h0);
        check({31'h0, full_power_out}, 32'h0);
        check({31'h0, sleeping}, 32'h0);
        end_sim();
    end
endmodule
